// ### otp_defines.svh
`ifndef OTP_DEFINES_SVH
`define OTP_DEFINES_SVH

`define OTP_CLK_MHZ      50
`define OTP_WORDS        4074
`define OTP_LAST_ADDR    12'hFE9
`define OTP_ADDR_W       12
`define OTP_WORD_W       10
`define OTP_DATA_W       8
`define OTP_TRY_W        5
`define OTP_MAX_TRIES    5'h15

// Mode vector bit i is mode pin i
`define OTP_MD_CLEAR     4'h5
`define OTP_MD_WRITE     4'hE
`define OTP_MD_VERIFY    4'hC
`define OTP_MD_INHIBIT   4'hD
`define OTP_MD_INH_MASK  4'hD
`define OTP_MD_OFF       4'h0

`define OTP_T_RES_US     10
`define OTP_T_WAIT_US    2000
`define OTP_T_PCR_US     10
`define OTP_T_SET_US     2
`define OTP_T_PW_US      1000
`define OTP_T_XH_NS      125

`define OTP_RES_CYC      (`OTP_T_RES_US * `OTP_CLK_MHZ)
`define OTP_WAIT_CYC     (`OTP_T_WAIT_US * `OTP_CLK_MHZ)
`define OTP_PCR_CYC      (`OTP_T_PCR_US * `OTP_CLK_MHZ)
`define OTP_SET_CYC      (`OTP_T_SET_US * `OTP_CLK_MHZ)
`define OTP_PW_CYC       (`OTP_T_PW_US * `OTP_CLK_MHZ)
`define OTP_XH_CYC       ((`OTP_T_XH_NS * `OTP_CLK_MHZ + 999) / 1000)
`endif

// ### otp_pkg.sv
`default_nettype none
package otp_pkg;
  typedef enum logic [3:0] {
    P_IDLE, P_RESET, P_OSC, P_CLEAR, P_RAISE, P_INHIBIT, P_WRITE, P_WINH,
    P_VERIFY, P_EXTRA, P_XINH, P_ADV, P_FINAL, P_OFF
  } otp_pst_t;
  typedef enum logic [2:0] {
    M_IDLE, M_CLEAR, M_WRITE, M_VERIFY, M_INHIBIT
  } otp_dmode_t;
endpackage
`default_nettype wire

// ### otp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface otp_if;
  logic [3:0] prog_mode_select;
  logic       prog_clk;
  logic       pwr_on;
  logic       vpp_prog;
  logic [7:0] prg_d_o;
  logic       prg_d_oe_n;
  logic [7:0] dev_d_o;
  logic       dev_d_oe_n;
  logic [7:0] prog_data_bus;

  // Pull-downs hold the bus low when nobody drives
  assign prog_data_bus = !prg_d_oe_n ? prg_d_o : (!dev_d_oe_n ? dev_d_o : 8'h00);

  modport prog (output prog_mode_select, prog_clk, pwr_on, vpp_prog, prg_d_o, prg_d_oe_n,
                input  prog_data_bus);
  modport dev  (input  prog_mode_select, prog_clk, pwr_on, vpp_prog, prog_data_bus,
                output dev_d_o, dev_d_oe_n);
endinterface // otp_if
`default_nettype wire

// ### otp_dev.sv
`timescale 1ns/100ps
`default_nettype none
`include "otp_defines.svh"
module otp_dev
  import otp_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  otp_if.dev                          link,
  output logic                        prog_active,
  output logic [`OTP_ADDR_W-1:0]      cur_addr,
  output otp_dmode_t                  cur_mode
);
  logic [3:0]              md_s1, md_s2;
  logic                    ck_s1, ck_s2, ck_d;
  logic                    vp_s1, vp_s2;
  logic [`OTP_DATA_W-1:0]  d_s1, d_s2;
  logic [1:0]              pcnt, next_pcnt;
  logic [`OTP_ADDR_W-1:0]  next_addr;
  otp_dmode_t              next_mode;
  logic                    next_active;
  logic [`OTP_DATA_W-1:0]  d_o, next_d_o;
  logic                    d_oe_n, next_d_oe_n;
  logic                    fall, in_range, mem_we;
  logic [`OTP_WORD_W-1:0]  rdata;
  logic [`OTP_WORD_W-1:0]  mem [0:`OTP_WORDS-1];

  assign link.dev_d_o    = d_o;
  assign link.dev_d_oe_n = d_oe_n;

  // Pins come from the programmer's domain
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      md_s1 <= 4'h0;
      md_s2 <= 4'h0;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_d  <= 1'b0;
      vp_s1 <= 1'b0;
      vp_s2 <= 1'b0;
      d_s1  <= 8'h00;
      d_s2  <= 8'h00;
    end else begin
      md_s1 <= link.prog_mode_select;
      md_s2 <= md_s1;
      ck_s1 <= link.prog_clk;
      ck_s2 <= ck_s1;
      ck_d  <= ck_s2;
      vp_s1 <= link.vpp_prog;
      vp_s2 <= vp_s1;
      d_s1  <= link.prog_data_bus;
      d_s2  <= d_s1;
    end
  end

  always_comb begin
    fall        = ck_d & ~ck_s2;
    in_range    = (cur_addr <= `OTP_LAST_ADDR);
    rdata       = in_range ? mem[cur_addr] : 10'h000;
    next_mode   = M_IDLE;
    next_addr   = cur_addr;
    next_pcnt   = pcnt;
    if (vp_s2) begin
      if (md_s2 == `OTP_MD_CLEAR) begin
        next_mode = M_CLEAR;
      end else if (md_s2 == `OTP_MD_WRITE) begin
        next_mode = M_WRITE;
      end else if (md_s2 == `OTP_MD_VERIFY) begin
        next_mode = M_VERIFY;
      end else if ((md_s2 & `OTP_MD_INH_MASK) == `OTP_MD_INHIBIT) begin
        next_mode = M_INHIBIT;
      end else begin
        // Undefined codes behave as inhibit: safest for the fuses
        next_mode = M_INHIBIT;
      end
    end
    if (next_mode == M_CLEAR) begin
      next_addr = 12'h000;
      next_pcnt = 2'h0;
    end else if (vp_s2 && fall) begin
      next_pcnt = pcnt + 2'h1;
      if (pcnt == 2'h2) begin
        next_addr = cur_addr + 12'h001;
      end
    end
    // Only the low byte reaches the pins; top bits stay clear
    // Decoded mode and data share the same two sync stages; registered mode lags the bus
    mem_we      = (next_mode == M_WRITE) && in_range;
    next_d_o    = rdata[`OTP_DATA_W-1:0];
    next_d_oe_n = (cur_mode != M_VERIFY);
    next_active = (next_mode != M_IDLE);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cur_mode    <= M_IDLE;
      cur_addr    <= 12'h000;
      pcnt        <= 2'h0;
      d_o         <= 8'h00;
      d_oe_n      <= 1'b1;
      prog_active <= 1'b0;
    end else begin
      cur_mode    <= next_mode;
      cur_addr    <= next_addr;
      pcnt        <= next_pcnt;
      d_o         <= next_d_o;
      d_oe_n      <= next_d_oe_n;
      prog_active <= next_active;
    end
  end

  // No reset on the store: it models fused cells
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[cur_addr] <= {2'b00, d_s2};
    end
  end
endmodule // otp_dev
`default_nettype wire

// ### otp_prog.sv
`timescale 1ns/100ps
`default_nettype none
`include "otp_defines.svh"
module otp_prog
  import otp_pkg::*;
#(
  parameter int unsigned WAIT_CYC = `OTP_WAIT_CYC,
  parameter int unsigned PW_CYC   = `OTP_PW_CYC
) (
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  otp_if.prog                         link,
  input  wire logic                   start,
  input  wire logic                   read_mode,
  input  wire logic [`OTP_ADDR_W-1:0] word_count,
  input  wire logic [`OTP_DATA_W-1:0] wr_byte,
  output logic [`OTP_ADDR_W-1:0]      word_addr,
  output logic                        busy,
  output logic                        done,
  output logic                        fail,
  output logic                        rd_valid,
  output logic [`OTP_DATA_W-1:0]      rd_byte
);
  otp_pst_t                st, next_st;
  logic [31:0]             tmr, next_tmr;
  logic [1:0]              ph, next_ph;
  logic [`OTP_TRY_W-1:0]   tries, next_tries;
  logic [`OTP_DATA_W-1:0]  wbyte, next_wbyte;
  logic [`OTP_ADDR_W-1:0]  nwords, next_nwords, next_word_addr;
  logic                    rmode, next_rmode, failed, next_failed;
  logic [3:0]              md, next_md;
  logic                    pclk, next_pclk, pwr, next_pwr, vpp, next_vpp;
  logic [`OTP_DATA_W-1:0]  d_o, next_d_o, next_rd_byte;
  logic                    d_oe_n, next_d_oe_n;
  logic                    next_busy, next_done, next_fail, next_rd_valid;
  logic [`OTP_DATA_W-1:0]  din_s1, din_s2;
  logic                    tdone, last;

  assign link.prog_mode_select = md;
  assign link.prog_clk         = pclk;
  assign link.pwr_on           = pwr;
  assign link.vpp_prog         = vpp;
  assign link.prg_d_o          = d_o;
  assign link.prg_d_oe_n       = d_oe_n;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      din_s1 <= 8'h00;
      din_s2 <= 8'h00;
    end else begin
      din_s1 <= link.prog_data_bus;
      din_s2 <= din_s1;
    end
  end

  always_comb begin
    next_st        = st;
    next_tmr       = tmr;
    next_ph        = ph;
    next_tries     = tries;
    next_wbyte     = wbyte;
    next_nwords    = nwords;
    next_word_addr = word_addr;
    next_rmode     = rmode;
    next_failed    = failed;
    next_md        = md;
    next_pclk      = pclk;
    next_pwr       = pwr;
    next_vpp       = vpp;
    next_d_o       = d_o;
    next_d_oe_n    = d_oe_n;
    next_busy      = busy;
    next_rd_byte   = rd_byte;
    next_done      = 1'b0;
    next_fail      = 1'b0;
    next_rd_valid  = 1'b0;
    tdone          = (tmr == 32'h0);
    last           = ({1'b0, word_addr} + 13'h0001) >= {1'b0, nwords};
    if (!tdone) begin
      next_tmr = tmr - 32'h1;
    end
    case (st)
      P_IDLE: if (start) begin
        next_st        = P_RESET;
        next_busy      = 1'b1;
        next_pwr       = 1'b1;
        next_rmode     = read_mode;
        next_nwords    = word_count;
        next_word_addr = 12'h000;
        next_failed    = 1'b0;
        next_tries     = 5'h00;
        next_tmr       = 32'(`OTP_RES_CYC - 1);
      end
      P_RESET: if (tdone) begin
        next_st  = P_OSC;
        next_tmr = WAIT_CYC - 32'h1;
      end
      P_OSC: if (tdone) begin
        next_st  = P_CLEAR;
        next_md  = `OTP_MD_CLEAR;
        next_tmr = 32'(`OTP_PCR_CYC - 1);
      end
      P_CLEAR: if (tdone) begin
        next_st  = P_RAISE;
        next_vpp = 1'b1;
        next_tmr = 32'(`OTP_SET_CYC - 1);
      end
      P_RAISE: if (tdone) begin
        next_st  = P_INHIBIT;
        next_md  = `OTP_MD_INHIBIT;
        next_tmr = 32'(`OTP_SET_CYC - 1);
      end
      P_INHIBIT: if (tdone) begin
        if (rmode) begin
          next_st  = P_VERIFY;
          next_md  = `OTP_MD_VERIFY;
          next_tmr = 32'(`OTP_SET_CYC - 1);
        end else begin
          next_st     = P_WRITE;
          next_md     = `OTP_MD_WRITE;
          next_d_o    = wr_byte;
          next_d_oe_n = 1'b0;
          next_wbyte  = wr_byte;
          next_tries  = 5'h01;
          next_tmr    = PW_CYC - 32'h1;
        end
      end
      P_WRITE: if (tdone) begin
        next_st     = P_WINH;
        next_md     = `OTP_MD_INHIBIT;
        next_d_oe_n = 1'b1;
        next_tmr    = 32'(`OTP_SET_CYC - 1);
      end
      P_WINH: if (tdone) begin
        next_st  = P_VERIFY;
        next_md  = `OTP_MD_VERIFY;
        next_tmr = 32'(`OTP_SET_CYC - 1);
      end
      P_VERIFY: if (tdone) begin
        if (rmode) begin
          next_rd_byte  = din_s2;
          next_rd_valid = 1'b1;
          next_tmr      = last ? 32'(`OTP_SET_CYC - 1) : 32'(`OTP_XH_CYC - 1);
          next_st       = last ? P_XINH : P_ADV;
          next_md       = last ? `OTP_MD_INHIBIT : `OTP_MD_VERIFY;
        end else if (din_s2 == wbyte) begin
          next_st     = P_EXTRA;
          next_md     = `OTP_MD_WRITE;
          next_d_oe_n = 1'b0;
          next_tmr    = 32'(tries) * PW_CYC - 32'h1;
        end else if (tries == `OTP_MAX_TRIES) begin
          // More tries would push the extra write past its limit
          next_st     = P_FINAL;
          next_failed = 1'b1;
          next_md     = `OTP_MD_CLEAR;
          next_tmr    = 32'(`OTP_PCR_CYC - 1);
        end else begin
          next_st     = P_WRITE;
          next_md     = `OTP_MD_WRITE;
          next_d_oe_n = 1'b0;
          next_tries  = tries + 5'h01;
          next_tmr    = PW_CYC - 32'h1;
        end
      end
      P_EXTRA: if (tdone) begin
        next_st     = P_XINH;
        next_md     = `OTP_MD_INHIBIT;
        next_d_oe_n = 1'b1;
        next_tmr    = 32'(`OTP_SET_CYC - 1);
      end
      P_XINH: if (tdone) begin
        if (last) begin
          next_st  = P_FINAL;
          next_md  = `OTP_MD_CLEAR;
          next_tmr = 32'(`OTP_PCR_CYC - 1);
        end else begin
          next_st  = P_ADV;
          next_tmr = 32'(`OTP_XH_CYC - 1);
        end
      end
      P_ADV: if (tdone) begin
        // Clock idles low between groups, so each group is four full pulses
        next_pclk = ~pclk;
        next_tmr  = 32'(`OTP_XH_CYC - 1);
        if (pclk) begin
          next_ph = ph + 2'h1;
          if (ph == 2'h3) begin
            next_word_addr = word_addr + 12'h001;
            next_tmr       = 32'(`OTP_SET_CYC - 1);
            next_st        = rmode ? P_VERIFY : P_INHIBIT;
          end
        end
      end
      P_FINAL: if (tdone) begin
        next_st  = P_OFF;
        next_vpp = 1'b0;
        next_tmr = 32'(`OTP_SET_CYC - 1);
      end
      P_OFF: if (tdone) begin
        next_st   = P_IDLE;
        next_pwr  = 1'b0;
        next_md   = `OTP_MD_OFF;
        next_busy = 1'b0;
        next_done = 1'b1;
        next_fail = failed;
      end
      default: next_st = P_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st        <= P_IDLE;
      tmr       <= 32'h0;
      ph        <= 2'h0;
      tries     <= 5'h00;
      wbyte     <= 8'h00;
      nwords    <= 12'h000;
      word_addr <= 12'h000;
      rmode     <= 1'b0;
      failed    <= 1'b0;
      md        <= `OTP_MD_OFF;
      pclk      <= 1'b0;
      pwr       <= 1'b0;
      vpp       <= 1'b0;
      d_o       <= 8'h00;
      d_oe_n    <= 1'b1;
      busy      <= 1'b0;
      done      <= 1'b0;
      fail      <= 1'b0;
      rd_valid  <= 1'b0;
      rd_byte   <= 8'h00;
    end else begin
      st        <= next_st;
      tmr       <= next_tmr;
      ph        <= next_ph;
      tries     <= next_tries;
      wbyte     <= next_wbyte;
      nwords    <= next_nwords;
      word_addr <= next_word_addr;
      rmode     <= next_rmode;
      failed    <= next_failed;
      md        <= next_md;
      pclk      <= next_pclk;
      pwr       <= next_pwr;
      vpp       <= next_vpp;
      d_o       <= next_d_o;
      d_oe_n    <= next_d_oe_n;
      busy      <= next_busy;
      done      <= next_done;
      fail      <= next_fail;
      rd_valid  <= next_rd_valid;
      rd_byte   <= next_rd_byte;
    end
  end
endmodule // otp_prog
`default_nettype wire

// ### otp_link_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "otp_defines.svh"
module otp_link_asserts #(
  parameter int unsigned PW_CYC = 20
) (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic [3:0] prog_mode_select,
  input wire logic       prog_clk,
  input wire logic       pwr_on,
  input wire logic       vpp_prog,
  input wire logic [7:0] prg_d_o,
  input wire logic       prg_d_oe_n,
  input wire logic [7:0] dev_d_o,
  input wire logic       dev_d_oe_n,
  input wire logic [7:0] prog_data_bus
);
  logic [3:0]  md;
  logic [15:0] run;
  logic [15:0] next_run;
  logic [3:0]  next_md;
  // Saturates so a long idle never wraps into a short run
  always_comb begin
    next_md  = prog_mode_select;
    next_run = (prog_mode_select != md) ? 16'h0001 : run + {15'h0000, run != 16'hFFFF};
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      md  <= 4'h0;
      run <= 16'h0000;
    end else begin
      md  <= next_md;
      run <= next_run;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_clk_hi; prog_clk [*7]; endsequence
  sequence s_clk_lo; !prog_clk [*7]; endsequence
  a_clk_idle_low: assert property (!vpp_prog |-> !prog_clk)
    else $error("link clock moved without programming voltage");
  a_clk_high_w: assert property ($rose(prog_clk) |-> s_clk_hi)
    else $error("link clock high phase too short");
  a_clk_low_w: assert property ($fell(prog_clk) |-> s_clk_lo)
    else $error("link clock low phase too short");
  a_vpp_in_clear: assert property ($rose(vpp_prog) |-> prog_mode_select == `OTP_MD_CLEAR)
    else $error("voltages raised outside clear mode");
  a_off_in_clear: assert property ($fell(vpp_prog) |-> prog_mode_select == `OTP_MD_CLEAR)
    else $error("voltages dropped outside clear mode");
  a_clear_hold: assert property ($past(prog_mode_select) == `OTP_MD_CLEAR &&
      prog_mode_select != `OTP_MD_CLEAR |-> run >= `OTP_PCR_CYC)
    else $error("clear mode left too early");
  a_write_pulse: assert property ($past(prog_mode_select) == `OTP_MD_WRITE &&
      prog_mode_select != `OTP_MD_WRITE |-> run >= PW_CYC && prog_mode_select == `OTP_MD_INHIBIT)
    else $error("write pulse short or not followed by inhibit");
  a_write_max: assert property ($past(prog_mode_select) == `OTP_MD_WRITE &&
      prog_mode_select != `OTP_MD_WRITE |-> run <= `OTP_MAX_TRIES * PW_CYC)
    else $error("write pulse longer than the extra write limit");
  a_write_drives: assert property (prog_mode_select == `OTP_MD_WRITE |->
      !prg_d_oe_n && prog_data_bus == prg_d_o)
    else $error("programmer not driving data in write mode");
  a_verify_answer: assert property ($changed(prog_mode_select) && vpp_prog &&
      prog_mode_select == `OTP_MD_VERIFY |-> ##[4:5] !dev_d_oe_n)
    else $error("device did not answer verify mode");
  a_verify_release: assert property ($past(prog_mode_select) == `OTP_MD_VERIFY &&
      prog_mode_select != `OTP_MD_VERIFY |-> ##[4:5] dev_d_oe_n)
    else $error("device kept bus after verify");
  a_dev_quiet: assert property ((!vpp_prog) [*6] |-> dev_d_oe_n)
    else $error("device drove bus without programming voltage");
  a_dev_data: assert property (!dev_d_oe_n && prg_d_oe_n |-> prog_data_bus == dev_d_o)
    else $error("bus does not carry device data");
  c_power_up: cover property (pwr_on && $rose(vpp_prog));
endmodule // otp_link_asserts
`default_nettype wire

// ### otp_program_verify_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "otp_defines.svh"
module otp_program_verify_port_bench
  import otp_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        start = 1'b0;
  logic        read_mode = 1'b0;
  logic [11:0] word_count = 12'h000;
  logic [7:0]  wr_byte = 8'h00;
  logic [7:0]  salt = 8'h00;
  logic [11:0] word_addr, cur_addr, last_addr;
  logic        busy, done, fail, rd_valid, prog_active, clk_q;
  logic [7:0]  rd_byte;
  logic [4:0]  mv_q;
  otp_dmode_t  cur_mode, exp_mode;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          falls = 0;
  int          stable = 0;
  logic [7:0]  rd_q[$];

  otp_if i_otp_if();
  otp_dev i_otp_dev(.core_clk, .rstn, .link(i_otp_if), .prog_active, .cur_addr, .cur_mode);
  otp_prog #(.WAIT_CYC(20), .PW_CYC(20)) i_otp_prog(.core_clk, .rstn, .link(i_otp_if),
    .start, .read_mode, .word_count, .wr_byte, .word_addr, .busy, .done, .fail, .rd_valid,
    .rd_byte);
  otp_link_asserts #(.PW_CYC(20)) i_otp_link_asserts(.core_clk, .rstn,
    .prog_mode_select(i_otp_if.prog_mode_select), .prog_clk(i_otp_if.prog_clk),
    .pwr_on(i_otp_if.pwr_on), .vpp_prog(i_otp_if.vpp_prog), .prg_d_o(i_otp_if.prg_d_o),
    .prg_d_oe_n(i_otp_if.prg_d_oe_n), .dev_d_o(i_otp_if.dev_d_o),
    .dev_d_oe_n(i_otp_if.dev_d_oe_n), .prog_data_bus(i_otp_if.prog_data_bus));

  function automatic logic [7:0] pat(input logic [11:0] a);
    return {a[3:0], ~a[3:0]} ^ 8'h5A;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic start_job(input logic rd, input logic [11:0] cnt);
    @(negedge core_clk);
    start = 1'b1;
    read_mode = rd;
    word_count = cnt;
    @(negedge core_clk);
    start = 1'b0;
    check({14'h0, busy, i_otp_if.pwr_on}, 16'h3);
  endtask

  task automatic wait_done();
    for (int i = 0; i < 8000 && done !== 1'b1; i++) @(negedge core_clk);
    check({15'h0, done}, 16'h1);
    check({15'h0, fail}, 16'h0);
    check({15'h0, busy}, 16'h0);
    repeat (2) @(negedge core_clk);
    check({4'h0, cur_addr}, 16'h0);
    check({15'h0, prog_active}, 16'h0);
  endtask

  task automatic check_reads(input logic [11:0] first, input int n);
    check(16'(rd_q.size()), 16'(n));
    for (int i = 0; i < n && i < rd_q.size(); i++)
      check({8'h0, rd_q[i]}, {8'h0, pat(first + 12'(i))});
    rd_q.delete();
  endtask

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // Own view of the wire: falls since clear, and decode once pins settle
  always @(negedge core_clk) begin
    cycles++;
    wr_byte <= pat(word_addr) ^ salt;
    if (rd_valid === 1'b1) rd_q.push_back(rd_byte);
    if (clk_q === 1'b1 && i_otp_if.prog_clk === 1'b0) falls++;
    if (i_otp_if.prog_mode_select === `OTP_MD_CLEAR) falls = 0;
    clk_q = i_otp_if.prog_clk;
    if (cur_addr !== last_addr && cur_addr !== 12'h000) begin
      check({4'h0, cur_addr}, 16'((falls + 1) / 4));
      check(16'(falls % 4), 16'h3);
    end
    last_addr = cur_addr;
    stable = ({i_otp_if.vpp_prog, i_otp_if.prog_mode_select} !== mv_q) ? 0 : stable + 1;
    mv_q = {i_otp_if.vpp_prog, i_otp_if.prog_mode_select};
    if (stable == 6) begin
      case (i_otp_if.prog_mode_select)
        `OTP_MD_CLEAR:  exp_mode = M_CLEAR;
        `OTP_MD_WRITE:  exp_mode = M_WRITE;
        `OTP_MD_VERIFY: exp_mode = M_VERIFY;
        default:        exp_mode = M_INHIBIT;
      endcase
      if (i_otp_if.vpp_prog !== 1'b1) exp_mode = M_IDLE;
      check(16'(cur_mode), 16'(exp_mode));
      check({15'h0, prog_active}, {15'h0, i_otp_if.vpp_prog});
    end
    if (cycles > 30000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    repeat (16) @(negedge core_clk);
    rstn = 1'b1;
    start_job(1'b0, 12'h003);
    wait_done();
    $display("test write of three words done");
    start_job(1'b1, 12'h003);
    wait_done();
    check_reads(12'h000, 3);
    $display("test sequential read done");
    // A write attempt while busy must leave the store untouched
    start_job(1'b1, 12'h001);
    repeat (300) @(negedge core_clk);
    salt = 8'hFF;
    start_job(1'b0, 12'h003);
    wait_done();
    check_reads(12'h000, 1);
    start_job(1'b1, 12'h003);
    wait_done();
    check_reads(12'h000, 3);
    $display("test ignored start and back to back done");
    wrap_up();
  end
endmodule // otp_program_verify_port_bench
`default_nettype wire
